// ---- hw/nvs_slave.sv ----
// Two-wire serial slave in front of a 512-byte array
// Operation
// - 512 bytes, each picked by a 9-bit address: page bit plus word.
// - Word address byte selects one of 256 locations in the page.
// - Page is one bit, giving two pages of 256 bytes.
// - Respond only when select pins match address bits 3-2.
// - Select pins read as zero when unconnected.
// - Launch bits on falling SCL, capture on rising SCL.
// - Write protect high blocks all array writes.
// - Write protect low allows all writes.
// - Write protect reads as zero when unconnected.
// - SDA is only pulled low, otherwise released.
// - Each received data byte is written to the array at once when write protect is low.
// - No busy period; next transaction accepted right after a write.
// - Bytes move serially, one bit per SCL cycle, MSB first.
// - Works at SCL up to 1 MHz, and at 100 and 400 kHz.
// - Reset, STOP, a read no-acknowledge or a non-matching first byte bring the interface to idle.
// - First byte: type 7-4, select 3-2, page 1, read/write 0.
// - Address increments after each data byte, wrapping 1FF to 000.
// - Reads continue while master acknowledges; no-acknowledge ends them.
// - Write happens after bit eight; START or STOP earlier aborts it.
`timescale 1ns/100ps
module nvs_slave (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic reset_in,
   // Serial bus
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // Straps, pulled low outside when unconnected
   input wire logic [1:0] device_select_pins_in,
   input wire logic write_protect_in
);
   nvs_pkg::nvs_bus_t bus;
   nvs_pkg::nvs_wr_t wr_q, wr_d;
   nvs_pkg::nvs_state_t state_q, state_d;
   logic [1:0] sel_meta_q, sel_q;
   logic wp_meta_q, wp_q;
   logic [8:0] addr_q, addr_d;
   logic [7:0] shift_q, shift_d;
   logic [3:0] bit_q, bit_d;
   logic drive_q, drive_d;
   logic ack_phase_q, ack_phase_d;
   logic is_read_q, is_read_d;
   logic [7:0] rd_data;

   // Eight bits of the current byte have been clocked
   function automatic logic byte_done(input logic [3:0] b);
      return b == nvs_pkg::BIT_LAST + 4'h1;
   endfunction

   nvs_sync u_sync (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .bus_out(bus)
   );

   nvs_array u_array (
      .core_clk_in(core_clk_in),
      .wr_in(wr_q),
      .rd_addr_in(addr_q),
      .rd_data_out(rd_data)
   );

   // Straps synchronised; pins are pulled down so open reads zero
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         sel_meta_q <= 2'h0;
         sel_q <= 2'h0;
         wp_meta_q <= 1'b0;
         wp_q <= 1'b0;
      end else begin
         sel_meta_q <= device_select_pins_in;
         sel_q <= sel_meta_q;
         wp_meta_q <= write_protect_in;
         wp_q <= wp_meta_q;
      end
   end

   always_comb begin
      state_d = state_q;
      addr_d = addr_q;
      shift_d = shift_q;
      bit_d = bit_q;
      drive_d = drive_q;
      ack_phase_d = ack_phase_q;
      is_read_d = is_read_q;
      wr_d = '0;
      if (bus.start) begin
         // Abort anything in flight; partial byte is never written
         state_d = nvs_pkg::ST_DEV;
         bit_d = nvs_pkg::BIT_RESET;
         drive_d = 1'b0;
         ack_phase_d = 1'b0;
      end else if (bus.stop) begin
         state_d = nvs_pkg::ST_IDLE;
         drive_d = 1'b0;
         ack_phase_d = 1'b0;
      end else if (bus.rise) begin
         if (ack_phase_q) begin
            // Ninth clock: only a read checks the master's answer
            if (state_q == nvs_pkg::ST_RDATA && bus.sda) begin
               state_d = nvs_pkg::ST_IDLE;
            end
         end else if (state_q != nvs_pkg::ST_IDLE && state_q != nvs_pkg::ST_RDATA) begin
            shift_d = {shift_q[6:0], bus.sda};
            bit_d = bit_q + 4'h1;
         end else if (state_q == nvs_pkg::ST_RDATA) begin
            bit_d = bit_q + 4'h1;
         end
      end else if (bus.fall) begin
         if (ack_phase_q) begin
            // End of the acknowledge clock
            ack_phase_d = 1'b0;
            drive_d = 1'b0;
            bit_d = nvs_pkg::BIT_RESET;
            if (state_q == nvs_pkg::ST_RDATA) begin
               drive_d = ~rd_data[7];
               shift_d = {rd_data[6:0], 1'b1};
            end
         end else if (byte_done(bit_q)) begin
            ack_phase_d = 1'b1;
            unique case (state_q)
               nvs_pkg::ST_DEV: begin
                  if (shift_q[7:nvs_pkg::TYPE_POS] == nvs_pkg::TYPE_CODE &&
                      shift_q[3:nvs_pkg::SEL_POS] == sel_q) begin
                     drive_d = 1'b1;
                     addr_d[8] = shift_q[nvs_pkg::PAGE_POS];
                     is_read_d = shift_q[nvs_pkg::RW_POS];
                     state_d = shift_q[nvs_pkg::RW_POS] ? nvs_pkg::ST_RDATA : nvs_pkg::ST_WADDR;
                  end else begin
                     ack_phase_d = 1'b0;
                     state_d = nvs_pkg::ST_IDLE;
                  end
               end
               nvs_pkg::ST_WADDR: begin
                  addr_d[7:0] = shift_q;
                  drive_d = 1'b1;
                  state_d = nvs_pkg::ST_WDATA;
               end
               nvs_pkg::ST_WDATA: begin
                  // Commit after bit eight, before the ack
                  wr_d.en = ~wp_q;
                  wr_d.addr = addr_q;
                  wr_d.data = shift_q;
                  addr_d = addr_q + 9'h001;
                  drive_d = 1'b1;
               end
               nvs_pkg::ST_RDATA: begin
                  addr_d = addr_q + 9'h001;
                  drive_d = 1'b0;
               end
               default: begin
                  ack_phase_d = 1'b0;
                  state_d = nvs_pkg::ST_IDLE;
               end
            endcase
         end else if (state_q == nvs_pkg::ST_RDATA) begin
            drive_d = ~shift_q[7];
            shift_d = {shift_q[6:0], 1'b1};
         end
      end
   end

   // Read first byte: after the device address ack the low edge loads data
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         state_q <= nvs_pkg::ST_IDLE;
         addr_q <= nvs_pkg::ADDR_RESET;
         shift_q <= nvs_pkg::BYTE_RESET;
         bit_q <= nvs_pkg::BIT_RESET;
         drive_q <= 1'b0;
         ack_phase_q <= 1'b0;
         is_read_q <= 1'b0;
         wr_q <= '0;
      end else begin
         state_q <= state_d;
         addr_q <= addr_d;
         shift_q <= shift_d;
         bit_q <= bit_d;
         drive_q <= drive_d;
         ack_phase_q <= ack_phase_d;
         is_read_q <= is_read_d;
         wr_q <= wr_d;
      end
   end

   // Open drain: data is always low, enable pulls the line
   assign sda_out = 1'b0;
   assign sda_oe_out = drive_q;

   // Named sequences for byte ends and the acknowledge clock
   sequence s_eighth_fall;
      bus.fall && !ack_phase_q && byte_done(bit_q) && state_q == nvs_pkg::ST_WDATA;
   endsequence
   sequence s_addr_fall;
      bus.fall && !ack_phase_q && byte_done(bit_q) && state_q == nvs_pkg::ST_WADDR;
   endsequence
   sequence s_read_fall;
      bus.fall && !ack_phase_q && byte_done(bit_q) && state_q == nvs_pkg::ST_RDATA;
   endsequence
   sequence s_dev_fall;
      bus.fall && !ack_phase_q && byte_done(bit_q) && state_q == nvs_pkg::ST_DEV;
   endsequence
   sequence s_ack_fall;
      bus.fall && ack_phase_q;
   endsequence
   sequence s_ack_rise;
      bus.rise && ack_phase_q;
   endsequence

   a_write_commit: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (s_eighth_fall and !wp_q) |=> wr_q.en && wr_q.data == $past(shift_q))
      else $error("byte not committed after bit eight");
   a_protect_blocks: assert property (@(posedge core_clk_in) disable iff (reset_in)
      wp_q && $past(wp_q) |-> !wr_q.en)
      else $error("write reached array while protected");
   a_protect_ack: assert property (@(posedge core_clk_in) disable iff (reset_in)
      s_eighth_fall |=> drive_q && addr_q == $past(addr_q) + 9'h001)
      else $error("data byte not acked or address not advanced");
   a_sda_low_only: assert property (@(posedge core_clk_in) disable iff (reset_in)
      sda_oe_out |-> sda_out == 1'b0 && (ack_phase_q || state_q == nvs_pkg::ST_RDATA))
      else $error("sda driven high");
   a_abort_start: assert property (@(posedge core_clk_in) disable iff (reset_in)
      bus.start |=> state_q == nvs_pkg::ST_DEV && !wr_q.en && bit_q == 4'h0)
      else $error("start did not abort");
   a_abort_stop: assert property (@(posedge core_clk_in) disable iff (reset_in)
      bus.stop |=> state_q == nvs_pkg::ST_IDLE && !drive_q && !wr_q.en)
      else $error("stop did not abort");
   a_wrap_addr: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (s_eighth_fall and addr_q == nvs_pkg::ADDR_LAST) |=> addr_q == nvs_pkg::ADDR_RESET)
      else $error("address did not wrap");
   a_read_nack: assert property (@(posedge core_clk_in) disable iff (reset_in)
      bus.rise && ack_phase_q && state_q == nvs_pkg::ST_RDATA && bus.sda && !bus.start && !bus.stop
      |=> state_q == nvs_pkg::ST_IDLE)
      else $error("read not ended by nack");
   a_drive_on_fall: assert property (@(posedge core_clk_in) disable iff (reset_in)
      $rose(drive_q) |-> $past(bus.fall))
      else $error("sda changed off a falling edge");
   a_select_match: assert property (@(posedge core_clk_in) disable iff (reset_in)
      bus.fall && !ack_phase_q && bit_q == 4'h8 && state_q == nvs_pkg::ST_DEV
      && shift_q[3:2] != sel_q |=> state_q == nvs_pkg::ST_IDLE && !drive_q)
      else $error("responded to foreign select");

   // Device byte and address framing
   a_dev_ack: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (s_dev_fall and shift_q[7:nvs_pkg::TYPE_POS] == nvs_pkg::TYPE_CODE
      && shift_q[3:nvs_pkg::SEL_POS] == sel_q)
      |=> drive_q && ack_phase_q && addr_q[8] == $past(shift_q[nvs_pkg::PAGE_POS])
      && is_read_q == $past(shift_q[nvs_pkg::RW_POS]))
      else $error("device byte not acked or decoded");
   a_type_reject: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (s_dev_fall and shift_q[7:nvs_pkg::TYPE_POS] != nvs_pkg::TYPE_CODE)
      |=> state_q == nvs_pkg::ST_IDLE && !drive_q)
      else $error("foreign device type acked");
   a_word_addr: assert property (@(posedge core_clk_in) disable iff (reset_in)
      s_addr_fall |=> addr_q[7:0] == $past(shift_q) && addr_q[8] == $past(addr_q[8]) && drive_q)
      else $error("word address not latched");
   a_rise_shift: assert property (@(posedge core_clk_in) disable iff (reset_in)
      bus.rise && !ack_phase_q && state_q != nvs_pkg::ST_IDLE && state_q != nvs_pkg::ST_RDATA
      |=> shift_q == {$past(shift_q[6:0]), $past(bus.sda)} && bit_q == $past(bit_q) + 4'h1)
      else $error("bit not captured on rising scl");
   a_bit_bound: assert property (@(posedge core_clk_in) disable iff (reset_in)
      bit_q <= 4'h8)
      else $error("bit count ran past one byte");
   a_write_window: assert property (@(posedge core_clk_in) disable iff (reset_in)
      wr_q.en |-> $past(bus.fall) && $past(state_q) == nvs_pkg::ST_WDATA && byte_done($past(bit_q)))
      else $error("array written outside the eighth bit");
   a_ack_end: assert property (@(posedge core_clk_in) disable iff (reset_in)
      s_ack_fall |=> !ack_phase_q && bit_q == nvs_pkg::BIT_RESET)
      else $error("ack clock not closed");

   // Read direction
   a_read_release: assert property (@(posedge core_clk_in) disable iff (reset_in)
      s_read_fall |=> !drive_q && ack_phase_q && addr_q == $past(addr_q) + 9'h001)
      else $error("read byte end not handled");
   a_read_first: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (s_ack_fall and state_q == nvs_pkg::ST_RDATA) |=> drive_q == !$past(rd_data[7]) && !ack_phase_q)
      else $error("first read bit not launched");
   a_read_shift: assert property (@(posedge core_clk_in) disable iff (reset_in)
      bus.fall && !ack_phase_q && !byte_done(bit_q) && state_q == nvs_pkg::ST_RDATA
      |=> drive_q == !$past(shift_q[7]))
      else $error("read bit not shifted out");
   a_read_continue: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (s_ack_rise and state_q == nvs_pkg::ST_RDATA && !bus.sda) |=> state_q == nvs_pkg::ST_RDATA)
      else $error("read stopped despite master ack");

   // Line ownership; the slave only ever pulls low
   a_read_drive: assert property (@(posedge core_clk_in) disable iff (reset_in)
      drive_q && !ack_phase_q |-> is_read_q && state_q == nvs_pkg::ST_RDATA)
      else $error("sda pulled outside read data or ack");
   a_ack_hold: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (s_ack_rise and state_q != nvs_pkg::ST_RDATA && state_q != nvs_pkg::ST_IDLE) |-> drive_q)
      else $error("slave ack missing at ninth clock");
   a_idle_quiet: assert property (@(posedge core_clk_in) disable iff (reset_in)
      state_q == nvs_pkg::ST_IDLE |-> !drive_q)
      else $error("sda pulled while idle");
   a_drive_latency: assert property (@(posedge core_clk_in) disable iff (reset_in)
      $changed(drive_q) |-> $past(bus.fall || bus.start || bus.stop))
      else $error("sda changed away from a bus event");
endmodule

// ---- hw/nvs_pkg.sv ----
// Shared constants and carrier types for the serial memory slave
package nvs_pkg;
   localparam int ADDR_W = 9;
   localparam int WORD_W = 8;
   localparam int MEM_DEPTH = 512;
   // Device type code; the value is arbitrary
   localparam logic [3:0] TYPE_CODE = 4'h6;
   localparam logic [8:0] ADDR_RESET = 9'h000;
   localparam logic [8:0] ADDR_LAST = 9'h1FF;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam int SEL_POS = 2;
   localparam int PAGE_POS = 1;
   localparam int RW_POS = 0;
   localparam int TYPE_POS = 4;
   localparam logic [3:0] BIT_RESET = 4'h0;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // Bus events decoded from synchronised pins
   typedef struct packed {
      logic scl;
      logic sda;
      logic rise;
      logic fall;
      logic start;
      logic stop;
   } nvs_bus_t;

   // Array write port
   typedef struct packed {
      logic en;
      logic [8:0] addr;
      logic [7:0] data;
   } nvs_wr_t;

   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_DEV = 6'b000010,
      ST_WADDR = 6'b000100,
      ST_WDATA = 6'b001000,
      ST_RDATA = 6'b010000,
      ST_ACK = 6'b100000
   } nvs_state_t;
endpackage

// ---- hw/nvs_sync.sv ----
// Two-flop synchronisers and bus event detection for SCL and SDA
`timescale 1ns/100ps
module nvs_sync (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic reset_in,
   // Pins
   input wire logic scl_in,
   input wire logic sda_in,
   // Events
   output nvs_pkg::nvs_bus_t bus_out
);
   logic [1:0] scl_meta_q, scl_meta_d;
   logic [1:0] sda_meta_q, sda_meta_d;
   logic scl_q, scl_d, sda_q, sda_d;
   nvs_pkg::nvs_bus_t bus_q, bus_d;

   always_comb begin
      scl_meta_d = {scl_meta_q[0], scl_in};
      sda_meta_d = {sda_meta_q[0], sda_in};
      scl_d = scl_meta_q[1];
      sda_d = sda_meta_q[1];
      // Edges and conditions from synchronised levels only
      // Three clocks of latency, far inside a 1 MHz SCL half period
      bus_d.scl = scl_meta_q[1];
      bus_d.sda = sda_meta_q[1];
      bus_d.rise = scl_meta_q[1] & ~scl_q;
      bus_d.fall = ~scl_meta_q[1] & scl_q;
      bus_d.start = scl_meta_q[1] & scl_q & sda_q & ~sda_meta_q[1];
      bus_d.stop = scl_meta_q[1] & scl_q & ~sda_q & sda_meta_q[1];
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         scl_meta_q <= 2'h3;
         sda_meta_q <= 2'h3;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         bus_q <= '0;
      end else begin
         scl_meta_q <= scl_meta_d;
         sda_meta_q <= sda_meta_d;
         scl_q <= scl_d;
         sda_q <= sda_d;
         bus_q <= bus_d;
      end
   end

   assign bus_out = bus_q;
endmodule

// ---- hw/nvs_array.sv ----
// 512 x 8 storage array, synchronous write with registered read that returns the old data on a same-address write
`timescale 1ns/100ps
module nvs_array (
   // Clock
   input wire logic core_clk_in,
   // Access
   input nvs_pkg::nvs_wr_t wr_in,
   input wire logic [8:0] rd_addr_in,
   output logic [7:0] rd_data_out
);
   logic [7:0] mem [0:nvs_pkg::MEM_DEPTH-1];
   logic [7:0] rd_q;

   // No reset on the array; contents stand for nonvolatile data
   always_ff @(posedge core_clk_in) begin
      if (wr_in.en) begin
         mem[wr_in.addr] <= wr_in.data;
      end
      rd_q <= mem[rd_addr_in];
   end

   assign rd_data_out = rd_q;
endmodule

// ---- tb/nvs_master.sv ----
// Bus master model driving SCL and pulling SDA for the serial memory slave
`timescale 1ns/100ps
module nvs_master (
   // Clock
   input wire logic core_clk_in,
   // Bus
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_oe_out
);
   logic idle = 1'b1;
   initial begin
      scl_out = 1'b1;
      sda_oe_out = 1'b0;
   end
   task automatic w(input int n);
      repeat (n) @(negedge core_clk_in);
   endtask
   // Low 50 ns, high 30 ns: the slave needs four cycles after SCL falls to turn SDA round
   task automatic bit_xfer(input logic b, output logic r);
      scl_out = 1'b0;
      w(5);
      sda_oe_out = ~b;
      w(5);
      scl_out = 1'b1;
      w(3);
      r = sda_in;
      w(3);
   endtask
   // SCL stays high between frames, so a repeated start must first drop it
   task automatic start();
      if (!idle) begin
         scl_out = 1'b0;
         w(5);
         sda_oe_out = 1'b0;
         w(5);
         scl_out = 1'b1;
      end
      w(5);
      sda_oe_out = 1'b1;
      w(5);
      idle = 1'b0;
   endtask
   task automatic stop();
      scl_out = 1'b0;
      w(5);
      sda_oe_out = 1'b1;
      w(5);
      scl_out = 1'b1;
      w(5);
      sda_oe_out = 1'b0;
      w(8);
      idle = 1'b1;
   endtask
   // A count below eight leaves the byte unfinished
   task automatic put_byte(input logic [7:0] d, input int n, output logic ack);
      logic r;
      for (int i = 7; i > 7 - n; i--) bit_xfer(d[i], r);
      if (n == 8) bit_xfer(1'b1, r);
      ack = ~r;
   endtask
   task automatic get_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 0; i < 8; i++) begin
         bit_xfer(1'b1, r);
         d = {d[6:0], r};
      end
      bit_xfer(last, r);
   endtask
endmodule

// ---- tb/nvs_slave_tb.sv ----
// Self-checking bench for the serial memory slave
`timescale 1ns/100ps
module nvs_slave_tb;
   localparam logic [1:0] SEL = 2'b10;
   localparam int LIMIT = 40000;
   logic core_clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic scl;
   logic m_oe;
   logic sda_out;
   logic sda_oe_out;
   logic [1:0] sel_pins = SEL;
   logic wp = 1'b0;
   logic sda_wire;
   int fails = 0;
   int checked = 0;
   int cycles = 0;
   // Pull-up: high unless some party pulls low
   assign sda_wire = !m_oe && (sda_oe_out ? sda_out : 1'b1);
   nvs_slave DUT (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .scl_in(scl),
      .sda_in(sda_wire),
      .sda_out(sda_out),
      .sda_oe_out(sda_oe_out),
      .device_select_pins_in(sel_pins),
      .write_protect_in(wp)
   );
   nvs_master M (
      .core_clk_in(core_clk_in),
      .sda_in(sda_wire),
      .scl_out(scl),
      .sda_oe_out(m_oe)
   );
   initial begin
      forever #2.5 core_clk_in = ~core_clk_in;
   end
   task automatic summarize();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge core_clk_in) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         fails = fails + 1;
         summarize();
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      checked = checked + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("MISMATCH t=%0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   function automatic logic [7:0] dev(input logic [8:0] a, input logic rd);
      return {nvs_pkg::TYPE_CODE, SEL, a[8], rd};
   endfunction
   task automatic hdr(input logic [8:0] a);
      logic ack;
      M.start();
      M.put_byte(dev(a, 1'b0), 8, ack);
      chk(8'(ack), 8'h01, "device ack");
      M.put_byte(a[7:0], 8, ack);
      chk(8'(ack), 8'h01, "word address ack");
   endtask
   task automatic wr(input logic [8:0] a, input logic [7:0] base, input int n);
      logic ack;
      hdr(a);
      for (int i = 0; i < n; i++) begin
         M.put_byte(base + 8'(i), 8, ack);
         chk(8'(ack), 8'h01, "data ack");
      end
      M.stop();
   endtask
   task automatic rd(input logic [8:0] a, input logic [7:0] base, input int n);
      logic ack;
      logic [7:0] d;
      hdr(a);
      M.start();
      M.put_byte(dev(a, 1'b1), 8, ack);
      for (int i = 0; i < n; i++) begin
         M.get_byte(i == n - 1, d);
         chk(d, base + 8'(i), "read data");
      end
      M.stop();
   endtask
   task automatic t_wrap();
      wr(9'h1FF, 8'hC0, 2);
      rd(9'h1FF, 8'hC0, 1);
      rd(9'h000, 8'hC1, 1);
      wr(9'h0F0, 8'h40, 3);
      wr(9'h1F0, 8'h80, 1);
      rd(9'h0F0, 8'h40, 3);
      rd(9'h1F0, 8'h80, 1);
      chk(8'(sda_out), 8'h00, "sda only pulled low");
   endtask
   task automatic t_select();
      logic ack;
      for (int s = 0; s < 5; s++) begin
         M.start();
         M.put_byte(s < 4 ? {nvs_pkg::TYPE_CODE, 2'(s), 2'b00} : 8'h58, 8, ack);
         chk(8'(ack), 8'(s == int'(SEL)), "select match");
         M.stop();
      end
   endtask
   task automatic t_protect();
      logic [7:0] d;
      logic ack;
      wp = 1'b1;
      wr(9'h0F0, 8'h99, 2);
      wp = 1'b0;
      // No word address: the read continues after the blocked bytes
      M.start();
      M.put_byte(dev(9'h0F2, 1'b1), 8, ack);
      M.get_byte(1'b1, d);
      chk(d, 8'h42, "address after blocked write");
      M.stop();
      rd(9'h0F0, 8'h40, 2);
   endtask
   task automatic t_abort();
      logic ack;
      wr(9'h020, 8'h11, 2);
      hdr(9'h020);
      M.put_byte(8'hEE, 7, ack);
      M.stop();
      hdr(9'h021);
      M.put_byte(8'hEE, 5, ack);
      M.start();
      M.stop();
      rd(9'h020, 8'h11, 2);
   endtask
   initial begin
      repeat (3) @(negedge core_clk_in);
      reset_in = 1'b0;
      chk(8'(sda_oe_out), 8'h00, "idle after reset");
      repeat (4) @(negedge core_clk_in);
      t_wrap();
      t_select();
      t_protect();
      t_abort();
      summarize();
   end
endmodule
